//--- rtl/uii_char_timer.v
// character time-out timer of the rx fifo.
// assumes activity is a one-cycle pulse per fifo write or read.
`timescale 1ns/1ps
`default_nettype none

module uii_char_timer #(
   parameter TIMEOUT_CYCLES = 13888,
   parameter CW             = 24
) (
   // clock and reset
   input  wire          clk,
   input  wire          reset,
   // fifo state
   input  wire          fifo_nonempty,
   input  wire          activity,
   // time-out flag
   output reg           timeout
);

   localparam integer  LAST_INT = TIMEOUT_CYCLES - 1;
   localparam [CW-1:0] LAST     = LAST_INT[CW-1:0];

   reg [CW-1:0] count;

   // ************************************************************
   // idle counter
   // ************************************************************
   // any activity or an empty fifo restarts the count and drops the flag
   always @(posedge clk) begin
      if (reset || activity || !fifo_nonempty) begin
         count   <= {CW{1'b0}};
         timeout <= 1'b0;
      end else if (count == LAST) begin
         timeout <= 1'b1;           // held until the next activity, an empty fifo or reset
      end else begin
         count <= count + 1'b1;
      end
   end

endmodule // uii_char_timer
`default_nettype wire

//--- rtl/uii_regs.vh
// register map, field positions, reset values and timing counts for the
// uart interrupt identification block.
// assumes a 32-bit avalon-mm byte address and a 40 mhz clock.
`ifndef UII_REGS_VH
`define UII_REGS_VH

// ************************************************************
// register byte addresses
// ************************************************************
`define UII_ADDR_IER    32'he0010004
`define UII_ADDR_IIR    32'he0010008
`define UII_ADDR_FCR    32'he0010008
`define UII_ADDR_LSR    32'he0010014
`define UII_ADDR_STAT   32'he0010040
`define UII_ADDR_MASK   32'he0010044

// ************************************************************
// field positions
// ************************************************************
`define UII_IER_RDA     0
`define UII_IER_TX_HOLDING_EMPTY_IRQ    1
`define UII_IER_RLS     2
`define UII_IER_MODEM   3
`define UII_IER_ABTO    8
`define UII_IER_ABEO    9
`define UII_FCR_EN      0
`define UII_FCR_TRIG_HI 7
`define UII_FCR_TRIG_LO 6
`define UII_IIR_PEND    0
`define UII_IIR_ABEO    8
`define UII_IIR_ABTO    9

// ************************************************************
// source codes and reset values
// ************************************************************
`define UII_ID_RLS      3'h3
`define UII_ID_RDA      3'h2
`define UII_ID_CTI      3'h6
`define UII_ID_TX_HOLDING_EMPTY_IRQ     3'h1
`define UII_ID_MODEM    3'h0
`define UII_IER_RESET   10'h000
`define UII_FCR_RESET   3'h0
`define UII_IIR_RESET   32'h00000001
`define UII_IER_MASK    10'h30f

// rx fifo trigger depths for selections 0..3
`define UII_TRIG0       5'h01
`define UII_TRIG1       5'h04
`define UII_TRIG2       5'h08
`define UII_TRIG3       5'h0e

// ************************************************************
// timing
// ************************************************************
`define UII_CLK_KHZ       40000
`define UII_CHAR_TIME_NS  86806
`define UII_CTI_CHARS     4
// scaled to megahertz first so the product stays inside 32-bit integers;
// limitation: the clock must be a whole number of megahertz
`define UII_CHAR_CYCLES   ((`UII_CHAR_TIME_NS * (`UII_CLK_KHZ / 1000)) / 1000)
`define UII_CTI_CYCLES    (`UII_CTI_CHARS * `UII_CHAR_CYCLES)

`endif

//--- rtl/uii_top.v
// uart interrupt prioritisation and identification with avalon-mm access.
// assumes the rx/tx datapaths, modem logic and auto-baud engine sit
// outside and deliver synchronous event pulses and levels on clk.
`timescale 1ns/1ps
`default_nettype none
`include "uii_regs.vh"

module uii_top #(
   parameter TIMEOUT_CYCLES = `UII_CTI_CYCLES,
   parameter FW             = 5
) (
   // clock and reset
   input  wire          clk,
   input  wire          reset,
   // avalon-mm slave
   input  wire [31:0]   address,
   input  wire          read,
   input  wire          write,
   input  wire [31:0]   writedata,
   output reg  [31:0]   readdata,
   output reg           waitrequest,
   // receive side events
   input  wire          overrun_error,
   input  wire          parity_error,
   input  wire          framing_error,
   input  wire          break_indication,
   input  wire [FW-1:0] rx_fifo_level,
   input  wire          rx_fifo_write,
   input  wire          rx_fifo_read,
   // transmit and modem side
   input  wire          tx_holding_empty,
   input  wire          tx_holding_write,
   input  wire          modem_status_pending,
   // auto-baud engine
   input  wire          autobaud_done_flag,
   input  wire          autobaud_timeout_flag,
   // interrupt output
   output reg           irq
);

   // ************************************************************
   // functions
   // ************************************************************
   // trigger depth for a fifo control selection
   function [FW-1:0] trig_depth;
      input [1:0] sel;
      begin
         case (sel)
            2'h0:    trig_depth = `UII_TRIG0;
            2'h1:    trig_depth = `UII_TRIG1;
            2'h2:    trig_depth = `UII_TRIG2;
            default: trig_depth = `UII_TRIG3;
         endcase
      end
   endfunction

   // full-word address match
   function hit;
      input [31:0] a;
      input [31:0] b;
      begin
         hit = (a == b);
      end
   endfunction

   // ************************************************************
   // bus handshake
   // ************************************************************
   localparam [1:0] BUS_IDLE = 2'b01;
   localparam [1:0] BUS_ACK  = 2'b10;

   reg [1:0] bus_state;
   wire      take = (read || write) && bus_state[0];
   wire      rd   = take && read;
   wire      wr   = take && write && !read;

   // a request is taken in idle, answered one cycle later, then released
   always @(posedge clk) begin
      if (reset) begin
         bus_state   <= BUS_IDLE;
         waitrequest <= 1'b1;
      end else begin
         case (bus_state)
            BUS_IDLE: begin
               if (take) begin
                  bus_state   <= BUS_ACK;
                  waitrequest <= 1'b0;
               end
            end
            BUS_ACK: begin
               bus_state   <= BUS_IDLE;
               waitrequest <= 1'b1;
            end
            default: begin
               bus_state   <= BUS_IDLE;
               waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // register access strobes
   wire rd_iir  = rd && hit(address, `UII_ADDR_IIR);
   wire rd_lsr  = rd && hit(address, `UII_ADDR_LSR);
   wire rd_stat = rd && hit(address, `UII_ADDR_STAT);
   wire wr_ier  = wr && hit(address, `UII_ADDR_IER);
   wire wr_fcr  = wr && hit(address, `UII_ADDR_FCR);
   wire wr_mask = wr && hit(address, `UII_ADDR_MASK);

   // ************************************************************
   // control registers
   // ************************************************************
   reg [9:0] interrupt_enable_reg;
   reg [2:0] fifo_control_reg;   // {trigger select, fifo enable}
   wire      fifo_en = fifo_control_reg[0];

   // software steers enables and fifo mode; reserved bits are dropped
   always @(posedge clk) begin
      if (reset) begin
         interrupt_enable_reg <= `UII_IER_RESET;
         fifo_control_reg     <= `UII_FCR_RESET;
      end else begin
         if (wr_ier)
            interrupt_enable_reg <= writedata[9:0] & `UII_IER_MASK;
         if (wr_fcr)
            fifo_control_reg <= {writedata[`UII_FCR_TRIG_HI:
                                           `UII_FCR_TRIG_LO],
                                 writedata[`UII_FCR_EN]};
      end
   end

   // ************************************************************
   // line status errors
   // ************************************************************
   // {break, framing, parity, overrun} kept in line status bits 4:1
   reg  [3:0] lsr_err;
   wire [3:0] err_in = {break_indication, framing_error,
                        parity_error, overrun_error};

   // a new error in the clearing read cycle survives the clear
   always @(posedge clk) begin
      if (reset)
         lsr_err <= 4'h0;
      else if (rd_lsr)
         lsr_err <= err_in;
      else
         lsr_err <= lsr_err | err_in;
   end

   // ************************************************************
   // transmit holding empty latch
   // ************************************************************
   reg  tx_holding_empty_irq_q;
   reg  tx_holding_empty_irq_irq;
   reg  [2:0] id_code;
   reg  irq_none;
   wire tx_holding_empty_irq_rise = tx_holding_empty && !tx_holding_empty_irq_q;
   wire tx_holding_empty_irq_clr  = tx_holding_write ||
                    (rd_iir && id_code == `UII_ID_TX_HOLDING_EMPTY_IRQ && !irq_none);

   // set on the empty edge; the set wins over a clear in the same cycle
   always @(posedge clk) begin
      if (reset) begin
         tx_holding_empty_irq_q   <= 1'b0;
         tx_holding_empty_irq_irq <= 1'b0;
      end else begin
         tx_holding_empty_irq_q <= tx_holding_empty;
         if (tx_holding_empty_irq_rise)
            tx_holding_empty_irq_irq <= 1'b1;
         else if (tx_holding_empty_irq_clr)
            tx_holding_empty_irq_irq <= 1'b0;
      end
   end

   // ************************************************************
   // receive data and time-out
   // ************************************************************
   wire rx_nonempty = (rx_fifo_level != {FW{1'b0}});
   wire rx_activity = rx_fifo_write || rx_fifo_read;
   wire rx_avail_raw;
   wire cti_raw;

   // without the fifo a single character is enough to report data
   assign rx_avail_raw = fifo_en ?
      (rx_fifo_level >= trig_depth(fifo_control_reg[2:1])) :
      rx_nonempty;

   // the timer restarts on every fifo read or write
   uii_char_timer #(
      .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
   ) u_timer (
      .clk           (clk),
      .reset         (reset),
      .fifo_nonempty (rx_nonempty),
      .activity      (rx_activity),
      .timeout       (cti_raw)
   );

   // ************************************************************
   // enabled sources
   // ************************************************************
   wire p_rls   = (lsr_err != 4'h0) &&
                  interrupt_enable_reg[`UII_IER_RLS];
   wire p_rda   = rx_avail_raw &&
                  interrupt_enable_reg[`UII_IER_RDA];
   wire p_cti   = cti_raw && interrupt_enable_reg[`UII_IER_RDA];
   wire p_tx_holding_empty_irq  = tx_holding_empty_irq_irq && interrupt_enable_reg[`UII_IER_TX_HOLDING_EMPTY_IRQ];
   wire p_modem = modem_status_pending &&
                  interrupt_enable_reg[`UII_IER_MODEM];
   wire p_abeo  = autobaud_done_flag &&
                  interrupt_enable_reg[`UII_IER_ABEO];
   wire p_abto  = autobaud_timeout_flag &&
                  interrupt_enable_reg[`UII_IER_ABTO];

   // ************************************************************
   // priority encoder
   // ************************************************************
   reg [2:0] next_id;
   reg       next_none;

   // fixed order; only the five legal codes can come out
   always @* begin
      next_none = 1'b0;
      if (p_rls)
         next_id = `UII_ID_RLS;
      else if (p_rda)
         next_id = `UII_ID_RDA;
      else if (p_cti)
         next_id = `UII_ID_CTI;
      else if (p_tx_holding_empty_irq)
         next_id = `UII_ID_TX_HOLDING_EMPTY_IRQ;
      else begin
         next_id   = `UII_ID_MODEM;
         next_none = !p_modem;
      end
   end

   // ************************************************************
   // identification snapshot
   // ************************************************************
   reg abeo_q;
   reg abto_q;

   // tracks the sources every cycle except at the edge that takes an
   // identification read; holding later would show a cleared source again
   // to a read that follows at the minimum spacing
   always @(posedge clk) begin
      if (reset) begin
         id_code  <= `UII_ID_MODEM;
         irq_none <= 1'b1;
         abeo_q   <= 1'b0;
         abto_q   <= 1'b0;
      end else if (!rd_iir) begin
         id_code  <= next_id;
         irq_none <= next_none;
         abeo_q   <= p_abeo;
         abto_q   <= p_abto;
      end
   end

   wire [31:0] iir_word = {22'h0, abto_q, abeo_q,
                           fifo_en, fifo_en,
                           2'b00, id_code, irq_none};

   // ************************************************************
   // event status, mask and interrupt line
   // ************************************************************
   reg  [6:0] ev_stat;
   reg  [6:0] ev_mask;
   reg  [6:0] src_q;
   wire [6:0] src_now = {p_abto, p_abeo, p_modem, p_tx_holding_empty_irq,
                         p_cti, p_rda, p_rls};
   wire [6:0] ev_new  = src_now & ~src_q;

   // each source's rising edge sets a sticky bit; a read of the status
   // word clears it, but an edge in that same cycle is kept
   always @(posedge clk) begin
      if (reset) begin
         ev_stat <= 7'h00;
         ev_mask <= 7'h00;
         src_q   <= 7'h00;
         irq     <= 1'b0;
      end else begin
         src_q <= src_now;
         if (rd_stat)
            ev_stat <= ev_new;
         else
            ev_stat <= ev_stat | ev_new;
         if (wr_mask)
            ev_mask <= writedata[6:0];
         irq <= |(ev_stat & ev_mask);
      end
   end

   // ************************************************************
   // read data
   // ************************************************************
   reg [31:0] next_rdata;

   // reserved bits and unmapped addresses read as zero
   always @* begin
      next_rdata = 32'h0;
      if (hit(address, `UII_ADDR_IIR))
         next_rdata = iir_word;
      else if (hit(address, `UII_ADDR_IER))
         next_rdata = {22'h0, interrupt_enable_reg};
      else if (hit(address, `UII_ADDR_LSR))
         next_rdata = {26'h0, tx_holding_empty, lsr_err, rx_nonempty};
      else if (hit(address, `UII_ADDR_STAT))
         next_rdata = {25'h0, ev_stat};
      else if (hit(address, `UII_ADDR_MASK))
         next_rdata = {25'h0, ev_mask};
   end

   // data is captured at the take edge and shown with waitrequest low
   always @(posedge clk) begin
      if (reset)
         readdata <= 32'h0;
      else if (rd)
         readdata <= next_rdata;
   end

endmodule // uii_top
`default_nettype wire

//--- tb/uii_host.sv
// processor model: avalon-mm master used by the interrupt handler.
// assumes a slave that answers with one low cycle of waitrequest.
`timescale 1ns/1ps
`default_nettype none

module uii_host (
   // clock and answer
   input  wire logic        clk,
   input  wire logic [31:0] readdata,
   input  wire logic        waitrequest,
   // request
   output logic      [31:0] address,
   output logic             read,
   output logic             write,
   output logic      [31:0] writedata
);
   // idle bus from time zero
   initial begin
      address = 32'h0;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
   end

   // read: hold until waitrequest is seen low, then release
   task automatic rd(input logic [31:0] a, output logic [31:0] d);
      @(posedge clk);
      address <= a;
      read <= 1'b1;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      d = readdata;
      read <= 1'b0;
   endtask

   // write: callers keep reserved bits at zero
   task automatic wr(input logic [31:0] a, input logic [31:0] v);
      @(posedge clk);
      address <= a;
      writedata <= v;
      write <= 1'b1;
      @(posedge clk);
      while (waitrequest !== 1'b0) @(posedge clk);
      write <= 1'b0;
   endtask
endmodule // uii_host
`default_nettype wire

//--- tb/uii_top_asserts.sv
// checker for the uart interrupt identification block.
// assumes it is bound to uii_top and sees only its bus ports.
`timescale 1ns/1ps
`default_nettype none
`include "uii_regs.vh"

module uii_top_asserts (
   // clock and reset
   input wire logic        clk,
   input wire logic        reset,
   // avalon-mm slave
   input wire logic [31:0] address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest
);
   // ************************************************************
   // enable shadow and assertions
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   logic [31:0] ier;
   logic        rd_iir;

   // taken identification read
   assign rd_iir = read && waitrequest && address == `UII_ADDR_IIR;

   // shadow copy, so gating is judged from the bus alone
   always @(posedge clk) begin
      if (reset)
         ier <= 32'h0;
      else if (write && waitrequest && address == `UII_ADDR_IER)
         ier <= writedata;
   end

   AST_TAKE: assert property ((read || write) && waitrequest
      |=> !waitrequest) else $error("request not answered");
   AST_ONE: assert property (!waitrequest |=> waitrequest)
      else $error("answer longer than one cycle");
   AST_CODE: assert property (rd_iir |=> readdata[3:1] != 3'h4
      && readdata[3:1] != 3'h5 && readdata[3:1] != 3'h7)
      else $error("reserved source code");
   AST_PEND: assert property (rd_iir |=> !readdata[0]
      || readdata[3:1] == 3'h0) else $error("idle word with a code");
   AST_RESV: assert property (rd_iir |=> readdata[5:4] == 2'h0
      && readdata[31:10] == 22'h0) else $error("reserved bits set");
   AST_FEN: assert property (rd_iir |=> readdata[7] == readdata[6])
      else $error("fifo enable bits differ");
   AST_RLS: assert property (rd_iir && !ier[2]
      |=> readdata[3:1] != `UII_ID_RLS) else $error("line error ungated");
   AST_ABEO: assert property (rd_iir |=> !readdata[8] || ier[9])
      else $error("auto-baud done ungated");
   AST_ABTO: assert property (rd_iir |=> !readdata[9] || ier[8])
      else $error("auto-baud time-out ungated");

   // main scenarios
   cover property (rd_iir ##1 readdata[3:1] == `UII_ID_RLS);
   cover property (rd_iir ##1 readdata[3:1] == `UII_ID_CTI);
   cover property (rd_iir ##1 readdata[3:1] == `UII_ID_TX_HOLDING_EMPTY_IRQ);
endmodule // uii_top_asserts

bind uii_top uii_top_asserts u_chk (.clk(clk), .reset(reset),
   .address(address), .read(read), .write(write),
   .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest));
`default_nettype wire

//--- tb/uii_top_tb.sv
// self-checking bench for the uart interrupt identification block.
// assumes the rtl header is on the include path; 40 mhz clock.
`timescale 1ns/1ps
`default_nettype none
`include "uii_regs.vh"

module uii_top_tb;
   // ************************************************************
   // signals and instances
   // ************************************************************
   logic        clk, reset, read, write, waitrequest, irq;
   logic [31:0] address, writedata, readdata, d;
   logic        ovr, par, frm, brk, fwr, frd, tem, twr, mdm, abd, abt;
   logic [4:0]  lvl;
   int          err_total = 0;
   int          checks_done = 0;
   int          cyc = 0;

   // short time-out so the idle case fits the run
   uii_top #(.TIMEOUT_CYCLES(20), .FW(5)) dut (.clk(clk), .reset(reset),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .overrun_error(ovr),
      .parity_error(par), .framing_error(frm), .break_indication(brk),
      .rx_fifo_level(lvl), .rx_fifo_write(fwr), .rx_fifo_read(frd),
      .tx_holding_empty(tem), .tx_holding_write(twr),
      .modem_status_pending(mdm), .autobaud_done_flag(abd),
      .autobaud_timeout_flag(abt), .irq(irq));
   uii_host host (.clk(clk), .readdata(readdata),
      .waitrequest(waitrequest), .address(address), .read(read),
      .write(write), .writedata(writedata));

   // clock
   always #12.5 clk = ~clk;

   // hang guard, well above the few hundred cycles needed
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         err_total++;
         close_out;
      end
   end

   // ************************************************************
   // tasks
   // ************************************************************
   task cmp(input logic [31:0] g, input logic [31:0] e,
            input logic [31:0] m);
      checks_done++;
      if ((g & m) !== (e & m)) begin
         err_total++;
         $display("Error t=%0t got=%h exp=%h", $time, g & m, e & m);
      end
   endtask
   task ck(input logic [31:0] a, input logic [31:0] e,
           input logic [31:0] m);
      host.rd(a, d);
      cmp(d, e, m);
   endtask
   task ci(input logic [31:0] e);
      ck(`UII_ADDR_IIR, e, 32'hffffffff);
   endtask
   task wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one fifo access with the new fill level
   task fifo(input logic w, input logic r, input logic [4:0] l);
      @(posedge clk);
      fwr <= w;
      frd <= r;
      lvl <= l;
      @(posedge clk);
      fwr <= 1'b0;
      frd <= 1'b0;
   endtask
   task close_out;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ************************************************************
   // sequence
   // ************************************************************
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      {ovr, par, frm, brk, fwr, frd, tem, twr, mdm, abd, abt} = 11'h0;
      lvl = 5'h0;
      wt(16);
      reset <= 1'b0;
      ci(32'h1);
      ck(32'he0010100, 32'h0, 32'hffffffff);
      host.wr(`UII_ADDR_FCR, 32'h41);
      ci(32'hc1);
      frm <= 1'b1;
      wt(1);
      frm <= 1'b0;
      ci(32'hc1);
      ck(`UII_ADDR_LSR, 32'h08, 32'h1e);
      {ovr, brk} <= 2'h3;
      wt(1);
      {ovr, brk} <= 2'h0;
      ck(`UII_ADDR_LSR, 32'h12, 32'h1e);
      $display("test setup done");
      host.wr(`UII_ADDR_IER, 32'h0f);
      par <= 1'b1;
      fifo(1'b1, 1'b0, 5'h4);
      par <= 1'b0;
      ci(32'hc6);
      ck(`UII_ADDR_LSR, 32'h04, 32'h1e);
      ci(32'hc4);
      fifo(1'b0, 1'b1, 5'h3);
      ci(32'hc1);
      wt(30);
      ci(32'hcc);
      fifo(1'b0, 1'b1, 5'h2);
      ci(32'hc1);
      fifo(1'b0, 1'b1, 5'h0);
      // without the fifo one character reports data
      host.wr(`UII_ADDR_FCR, 32'h0);
      fifo(1'b1, 1'b0, 5'h1);
      ci(32'h4);
      fifo(1'b0, 1'b1, 5'h0);
      // deepest trigger selection
      host.wr(`UII_ADDR_FCR, 32'hc1);
      fifo(1'b1, 1'b0, 5'hd);
      ci(32'hc1);
      fifo(1'b1, 1'b0, 5'he);
      ci(32'hc4);
      fifo(1'b0, 1'b1, 5'h0);
      $display("test rx done");
      tem <= 1'b1;
      wt(2);
      ci(32'hc2);
      ci(32'hc1);
      tem <= 1'b0;
      wt(2);
      tem <= 1'b1;
      wt(3);
      twr <= 1'b1;
      wt(1);
      twr <= 1'b0;
      ci(32'hc1);
      $display("test tx done");
      host.rd(`UII_ADDR_STAT, d);
      mdm <= 1'b1;
      wt(3);
      ci(32'hc0);
      cmp({31'h0, irq}, 32'h0, 32'h1);
      host.wr(`UII_ADDR_MASK, 32'h10);
      wt(2);
      cmp({31'h0, irq}, 32'h1, 32'h1);
      ck(`UII_ADDR_STAT, 32'h10, 32'h10);
      wt(2);
      cmp({31'h0, irq}, 32'h0, 32'h1);
      mdm <= 1'b0;
      $display("test irq done");
      host.wr(`UII_ADDR_IER, 32'h30f);
      abd <= 1'b1;
      wt(2);
      ck(`UII_ADDR_IIR, 32'h100, 32'h300);
      abd <= 1'b0;
      abt <= 1'b1;
      wt(2);
      ck(`UII_ADDR_IIR, 32'h200, 32'h300);
      host.wr(`UII_ADDR_IER, 32'h0f);
      wt(2);
      ck(`UII_ADDR_IIR, 32'h0, 32'h300);
      abt <= 1'b0;
      $display("test autobaud done");
      close_out;
   end
endmodule // uii_top_tb
`default_nettype wire
